// ===== pnm_pkg.sv
package pnm_pkg;
  localparam logic [15:0] PNM_DIR_OFS = 16'hffd0;
  localparam logic [15:0] PNM_DATA_OFS = 16'hffd2;
  localparam logic [7:0] PNM_DIR_RST = 8'hc0;
  localparam logic [7:0] PNM_DATA_RST = 8'hc0;
  localparam logic [7:0] PNM_PIN_MASK = 8'h15;
  localparam logic [7:0] PNM_LOOSE_MASK = 8'h2a;
  localparam logic [7:0] PNM_FIXED_ONES = 8'hc0;
  localparam int PNM_PIN4 = 4;
  localparam int PNM_PIN2 = 2;
  localparam int PNM_PIN0 = 0;
endpackage

// ===== pnm_port9.sv
// Function
// - Three pins at bits 4, 2, 0, each general input or output while its serial function is off
// - Direction bit 1 drives pin as output, 0 makes it an input
// - Direction register is write-only; reads return all ones
// - Direction register loads c0 on reset and hardware standby; kept otherwise
// - In software standby, output pins keep driving their level
// - Data read gives latch when direction is 1, pin level when 0
// - Data bits 7 and 6 ignore writes and read as one
// - Data bits 5, 3, 1 store values but reach no pin
// - Bits 5, 3, 1 read stored value if direction 1, else one
// - Data register loads c0 on reset and hardware standby; kept otherwise
// - Pin 4: clock input if select1; else clock output if sync or select0
// - Pin 2 is receive-data input while receive enable is set
`timescale 1ns/100ps
`default_nettype none
module pnm_port9
  import pnm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_n,
  input wire logic clock_select_bit0,
  input wire logic clock_select_bit1,
  input wire logic sync_mode_bit,
  input wire logic receive_enable_bit,
  input wire logic transmit_enable_bit,
  input wire logic serial_clock_out,
  input wire logic transmit_data,
  output logic serial_clock_in,
  output logic receive_data,
  output logic external_interrupt_request4
);

  ////////////////////////////////////////////////////////////////////////////
  // Function a shared pin performs at the moment
  typedef enum logic [1:0] {
    PNM_FN_GPIO_IN,
    PNM_FN_GPIO_OUT,
    PNM_FN_SER_IN,
    PNM_FN_SER_OUT
  } pnm_pin_fn_e;

  logic [7:0] sync1_reg;
  logic [7:0] sync1_next;
  logic [7:0] sync2_reg;
  logic [7:0] sync2_next;
  logic [7:0] dir_reg;
  logic [7:0] dir_next;
  logic [7:0] data_reg;
  logic [7:0] data_next;
  logic wr_dir_reg;
  logic wr_dir_next;
  logic wr_data_reg;
  logic wr_data_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic take;
  logic wr_take;
  logic rd_take;
  logic [7:0] wr_byte;
  logic [7:0] port_view;
  pnm_pin_fn_e pin4_fn;
  pnm_pin_fn_e pin2_fn;
  pnm_pin_fn_e pin0_fn;

  ////////////////////////////////////////////////////////////////////////////
  // Only the low half of the address is decoded; upper bits alias
  function automatic logic hit_dir(input logic [31:0] a);
    hit_dir = (a[15:0] == PNM_DIR_OFS);
  endfunction

  function automatic logic hit_data(input logic [31:0] a);
    hit_data = (a[15:0] == PNM_DATA_OFS);
  endfunction

  // Clock pin: external clock wins, then internal clock, then GPIO
  function automatic pnm_pin_fn_e clock_pin_fn(
    input logic sel1,
    input logic sel0,
    input logic sync_mode,
    input logic dir
  );
    if (sel1) begin
      clock_pin_fn = PNM_FN_SER_IN;
    end else if (sync_mode || sel0) begin
      clock_pin_fn = PNM_FN_SER_OUT;
    end else if (dir) begin
      clock_pin_fn = PNM_FN_GPIO_OUT;
    end else begin
      clock_pin_fn = PNM_FN_GPIO_IN;
    end
  endfunction

  // Pin shared with one serial signal of fixed direction
  function automatic pnm_pin_fn_e shared_pin_fn(
    input logic enable,
    input pnm_pin_fn_e serial_fn,
    input logic dir
  );
    if (enable) begin
      shared_pin_fn = serial_fn;
    end else if (dir) begin
      shared_pin_fn = PNM_FN_GPIO_OUT;
    end else begin
      shared_pin_fn = PNM_FN_GPIO_IN;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Zero wait states: every transfer ends in its first data phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;
  assign take = hsel && hready && htrans[1];
  assign wr_take = take && hwrite;
  assign rd_take = take && !hwrite;
  assign wr_byte = hwdata[7:0];

  // Write target is latched in the address phase, data comes one later
  always_comb begin
    wr_dir_next = wr_take && hit_dir(haddr);
    wr_data_next = wr_take && hit_data(haddr);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_dir_reg <= 1'b0;
      wr_data_reg <= 1'b0;
    end else begin
      wr_dir_reg <= wr_dir_next;
      wr_data_reg <= wr_data_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins are asynchronous to clk; two flops before any logic reads them
  always_comb begin
    sync1_next = pin_in;
    sync2_next = sync1_reg;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software standby is not decoded at all, so both registers hold
  always_comb begin
    dir_next = dir_reg;
    data_next = data_reg;
    if (wr_dir_reg) begin
      dir_next = wr_byte | PNM_FIXED_ONES;
    end
    if (wr_data_reg) begin
      data_next = wr_byte | PNM_FIXED_ONES;
    end
    // Standby entry wins over a write in its data phase
    if (hw_standby) begin
      dir_next = PNM_DIR_RST;
      data_next = PNM_DATA_RST;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_reg <= PNM_DIR_RST;
      data_reg <= PNM_DATA_RST;
    end else begin
      dir_reg <= dir_next;
      data_reg <= data_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-bit read view of the data register
  for (genvar g = 0; g < 8; g++) begin : g_view
    if (PNM_FIXED_ONES[g]) begin : g_fixed
      assign port_view[g] = 1'b1;
    end else if (PNM_PIN_MASK[g]) begin : g_pin
      assign port_view[g] = dir_reg[g] ? data_reg[g] : sync2_reg[g];
    end else begin : g_loose
      assign port_view[g] = dir_reg[g] ? data_reg[g] : 1'b1;
    end
  end

  // Read data is captured in the address phase and stands until the next
  always_comb begin
    rdata_next = rdata_reg;
    if (rd_take) begin
      if (hit_dir(haddr)) begin
        rdata_next = 32'h0000_00ff;
      end else if (hit_data(haddr)) begin
        rdata_next = {24'h00_0000, port_view};
      end else begin
        rdata_next = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin function selection
  always_comb begin
    pin4_fn = clock_pin_fn(
      clock_select_bit1,
      clock_select_bit0,
      sync_mode_bit,
      dir_reg[PNM_PIN4]
    );
    pin2_fn = shared_pin_fn(
      receive_enable_bit,
      PNM_FN_SER_IN,
      dir_reg[PNM_PIN2]
    );
    pin0_fn = shared_pin_fn(
      transmit_enable_bit,
      PNM_FN_SER_OUT,
      dir_reg[PNM_PIN0]
    );
  end

  // Loose bits never reach a pin; released pins drive low behind oe
  always_comb begin
    pin_out = 8'h00;
    pin_oe_n = 8'hff;
    unique case (pin4_fn)
      PNM_FN_SER_OUT: begin
        pin_out[PNM_PIN4] = serial_clock_out;
        pin_oe_n[PNM_PIN4] = 1'b0;
      end
      PNM_FN_GPIO_OUT: begin
        pin_out[PNM_PIN4] = data_reg[PNM_PIN4];
        pin_oe_n[PNM_PIN4] = 1'b0;
      end
      PNM_FN_SER_IN: begin
        pin_oe_n[PNM_PIN4] = 1'b1;
      end
      PNM_FN_GPIO_IN: begin
        pin_oe_n[PNM_PIN4] = 1'b1;
      end
    endcase
    unique case (pin2_fn)
      PNM_FN_SER_OUT: begin
        pin_oe_n[PNM_PIN2] = 1'b1;
      end
      PNM_FN_GPIO_OUT: begin
        pin_out[PNM_PIN2] = data_reg[PNM_PIN2];
        pin_oe_n[PNM_PIN2] = 1'b0;
      end
      PNM_FN_SER_IN: begin
        pin_oe_n[PNM_PIN2] = 1'b1;
      end
      PNM_FN_GPIO_IN: begin
        pin_oe_n[PNM_PIN2] = 1'b1;
      end
    endcase
    unique case (pin0_fn)
      PNM_FN_SER_OUT: begin
        pin_out[PNM_PIN0] = transmit_data;
        pin_oe_n[PNM_PIN0] = 1'b0;
      end
      PNM_FN_GPIO_OUT: begin
        pin_out[PNM_PIN0] = data_reg[PNM_PIN0];
        pin_oe_n[PNM_PIN0] = 1'b0;
      end
      PNM_FN_SER_IN: begin
        pin_oe_n[PNM_PIN0] = 1'b1;
      end
      PNM_FN_GPIO_IN: begin
        pin_oe_n[PNM_PIN0] = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial inputs see the pin two cycles late, as any other reader
  assign serial_clock_in = sync2_reg[PNM_PIN4];
  assign receive_data = sync2_reg[PNM_PIN2];

  // Forwarded in every pin function, so a driven clock also requests
  assign external_interrupt_request4 = sync2_reg[PNM_PIN4];

endmodule // pnm_port9
`default_nettype wire

// ===== pnm_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module pnm_monitor
  import pnm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic hready,
  input wire logic hwrite,
  input wire logic [1:0] htrans,
  input wire logic [31:0] haddr,
  input wire logic [31:0] hrdata,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  input wire logic clock_select_bit0,
  input wire logic clock_select_bit1,
  input wire logic sync_mode_bit,
  input wire logic receive_enable_bit,
  input wire logic transmit_enable_bit,
  input wire logic transmit_data,
  input wire logic serial_clock_out,
  input wire logic external_interrupt_request4
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire rd_take = hsel && hready && htrans[1] && !hwrite;
  chk_dir_ones: assert property (rd_take && haddr[15:0] == PNM_DIR_OFS
    |=> hrdata == 32'h0000_00ff) else $error("dir read");
  chk_data_fixed: assert property (rd_take && haddr[15:0] == PNM_DATA_OFS
    |=> hrdata[7:6] == 2'b11) else $error("fixed ones");
  chk_loose_pins: assert property (&pin_oe_n[7:5] && pin_oe_n[3]
    && pin_oe_n[1] && pin_out[3] == 1'b0) else $error("loose pin");
  chk_tx_pin: assert property (transmit_enable_bit |-> !pin_oe_n[0]
    && pin_out[0] == transmit_data) else $error("tx pin");
  chk_rx_pin: assert property (receive_enable_bit |-> pin_oe_n[2])
    else $error("rx pin");
  chk_sck_in: assert property (clock_select_bit1 |-> pin_oe_n[4])
    else $error("sck in");
  chk_sck_out: assert property (!clock_select_bit1
    && (sync_mode_bit || clock_select_bit0) |-> !pin_oe_n[4]
    && pin_out[4] == serial_clock_out) else $error("sck out");
  chk_irq_high: assert property (pin_in[4] [*3] |->
    external_interrupt_request4) else $error("irq high");
  chk_irq_low: assert property (!pin_in[4] [*3] |->
    !external_interrupt_request4) else $error("irq low");
endmodule // pnm_monitor
`default_nettype wire

// ===== pnm_board.sv
`timescale 1ns/100ps
`default_nettype none
module pnm_board (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  input wire logic [7:0] ext,
  output logic [7:0] pin_in
);
  // Released pins show the board level, driven ones echo the port
  assign pin_in = (pin_out & ~pin_oe_n) | (ext & pin_oe_n);
endmodule // pnm_board
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import pnm_pkg::*;
  logic clk, rst_n, hw_standby, sw_standby, hsel, hwrite, hready;
  logic hreadyout, hresp, clock_select_bit0, clock_select_bit1;
  logic sync_mode_bit, receive_enable_bit, transmit_enable_bit;
  logic serial_clock_out, transmit_data, serial_clock_in, receive_data;
  logic external_interrupt_request4;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [7:0] pin_in, pin_out, pin_oe_n, ext;
  int n_fail, samples_checked, cyc;
  assign hready = hreadyout;
  pnm_port9 pnm_port9_inst (.*);
  pnm_board pnm_board_inst (.pin_out, .pin_oe_n, .ext, .pin_in);
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  // Ceiling well above the roughly 60 cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      end_sim;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {16'h0, a};
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
    if (!w) chk(r, d);
  endtask
  task pins(input logic [15:0] exp);
    @(negedge clk);
    chk({16'h0, pin_out, pin_oe_n}, {16'h0, exp});
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    {rst_n, hw_standby, sw_standby, hwrite, htrans, ext} = 0;
    {clock_select_bit0, clock_select_bit1, sync_mode_bit} = 0;
    {receive_enable_bit, transmit_enable_bit, serial_clock_out} = 0;
    {transmit_data, haddr, hwdata} = 0;
    hsel = 1;
    hsize = 3'h2;
    repeat (10) @(posedge clk);
    rst_n <= 1;
    xfer(0, PNM_DIR_OFS, 32'hff);
    xfer(0, PNM_DATA_OFS, 32'hea);
    xfer(0, 16'hffd4, 32'h0);
    xfer(1, PNM_DIR_OFS, 32'h3f);
    xfer(1, PNM_DATA_OFS, 32'h00);
    xfer(0, PNM_DATA_OFS, 32'hc0);
    xfer(1, PNM_DATA_OFS, 32'h2a);
    xfer(0, PNM_DATA_OFS, 32'hea);
    pins(16'h00ea);
    xfer(1, PNM_DATA_OFS, 32'h15);
    sw_standby <= 1;
    repeat (3) @(posedge clk);
    pins(16'h15ea);
    @(posedge clk);
    sw_standby <= 0;
    xfer(1, PNM_DATA_OFS, 32'h00);
    hw_standby <= 1;
    @(posedge clk);
    hw_standby <= 0;
    xfer(0, PNM_DATA_OFS, 32'hea);
    ext <= 8'hff;
    repeat (3) @(posedge clk);
    xfer(0, PNM_DATA_OFS, 32'hff);
    {transmit_enable_bit, transmit_data, receive_enable_bit} <= 3'h7;
    clock_select_bit1 <= 1;
    ext <= 8'hef;
    repeat (3) @(posedge clk);
    @(negedge clk);
    r = {28'h0, serial_clock_in, receive_data, external_interrupt_request4,
      hresp};
    chk(r, 32'h4);
    @(posedge clk);
    {clock_select_bit1, sync_mode_bit, serial_clock_out} <= 3'h3;
    pins(16'h11ee);
    repeat (3) @(posedge clk);
    @(negedge clk);
    r = {28'h0, serial_clock_in, receive_data, external_interrupt_request4,
      hresp};
    chk(r, 32'he);
    end_sim;
  end
endmodule // tb_top
bind pnm_port9 pnm_monitor pnm_monitor_inst (.*);
`default_nettype wire
